/* File: rtl/rtc_sram_map.vh */
// constants for the battery-backed sram with clock window
// assumes a 10 MHz system clock; included by bare name
`ifndef RTC_SRAM_MAP_VH
`define RTC_SRAM_MAP_VH

`define ADDR_WIDTH 13
`define MEM_WORDS 8192
`define CLK_WIN_TAG 10'h3ff
`define CTRL_ADDR 13'h1ff8
`define CTRL_IDX 3'h0
`define CTRL_RST 8'h00
`define CTRL_FREEZE_BIT 6
`define CTRL_LOAD_BIT 7
`define CTRL_CAL_MSB 5
`define DATA_INVALID 8'hff

`define SEC_RST 8'h00
`define MIN_RST 8'h00
`define HOUR_RST 8'h00
`define DAY_RST 8'h01
`define DATE_RST 8'h01
`define MONTH_RST 8'h01
`define YEAR_RST 8'h00

`define CLK_PERIOD_NS 100
`define ACCESS_NS 100
`define ACCESS_CYC ((`ACCESS_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define PF_DESEL_NS 10000
`define PF_DESEL_CYC ((`PF_DESEL_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RECOVER_NS 1000
`define RECOVER_CYC ((`RECOVER_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RTC_DIV_DEFAULT 32768

`endif

/* File: rtl/pin_sync.v */
// three-flop synchroniser for a bundle of pins
// assumes pins are asynchronous to clk_sys; output moves when stages two and three agree
`timescale 1ns/10ps
module pin_sync #(
  parameter W = 8,
  parameter [W-1:0] RST_VAL = {W{1'b0}}
) (
  input wire clk_sys,
  input wire rst_n,
  input wire clkEn,
  input wire [W-1:0] pinIn,
  output reg [W-1:0] pinOut
);
  reg [W-1:0] stage1_r;
  reg [W-1:0] stage2_r;
  reg [W-1:0] stage3_r;
  integer i;

  always @(posedge clk_sys) begin
    if (!rst_n) begin
      stage1_r <= RST_VAL;
      stage2_r <= RST_VAL;
      stage3_r <= RST_VAL;
      pinOut <= RST_VAL;
    end else if (clkEn) begin
      stage1_r <= pinIn;
      stage2_r <= stage1_r;
      stage3_r <= stage2_r;
      for (i = 0; i < W; i = i + 1) begin
        if (stage2_r[i] == stage3_r[i]) begin
          pinOut[i] <= stage3_r[i];
        end
      end
    end
  end
endmodule

/* File: rtl/bcd_time_counter.v */
// running bcd time of day and calendar counters
// assumes a one-cycle second tick and a one-cycle load strobe from the same clock
`timescale 1ns/10ps
`include "rtc_sram_map.vh"
module bcd_time_counter (
  input wire clk_sys,
  input wire rst_n,
  input wire clkEn,
  input wire tick,
  input wire load,
  input wire [55:0] loadVal,
  output wire [55:0] timeVal
);
  reg [7:0] sec_r;
  reg [7:0] min_r;
  reg [7:0] hour_r;
  reg [7:0] day_r;
  reg [7:0] date_r;
  reg [7:0] month_r;
  reg [7:0] year_r;
  wire secWrap;
  wire minWrap;
  wire hourWrap;
  wire dateWrap;
  wire monthWrap;

  // bcd step with wrap from top to bottom
  function [7:0] bcdStep;
    input [7:0] v;
    input [7:0] top;
    input [7:0] bottom;
    begin
      if (v >= top) begin
        bcdStep = bottom;
      end else if (v[3:0] >= 4'h9) begin
        bcdStep = {v[7:4] + 4'h1, 4'h0};
      end else begin
        bcdStep = {v[7:4], v[3:0] + 4'h1};
      end
    end
  endfunction

  // last date of a month, leap when year divisible by four
  function [7:0] lastDate;
    input [7:0] mon;
    input [7:0] yr;
    reg leap;
    begin
      leap = yr[4] ? (yr[3:0] == 4'h2 || yr[3:0] == 4'h6)
                   : (yr[3:0] == 4'h0 || yr[3:0] == 4'h4 || yr[3:0] == 4'h8);
      case (mon)
        8'h02: lastDate = leap ? 8'h29 : 8'h28;
        8'h04, 8'h06, 8'h09, 8'h11: lastDate = 8'h30;
        default: lastDate = 8'h31;
      endcase
    end
  endfunction

  assign secWrap = (sec_r >= 8'h59);
  assign minWrap = secWrap && (min_r >= 8'h59);
  assign hourWrap = minWrap && (hour_r >= 8'h23);
  assign dateWrap = hourWrap && (date_r >= lastDate(month_r, year_r));
  assign monthWrap = dateWrap && (month_r >= 8'h12);
  assign timeVal = {year_r, month_r, date_r, day_r, hour_r, min_r, sec_r};

  always @(posedge clk_sys) begin
    if (!rst_n) begin
      sec_r <= `SEC_RST;
      min_r <= `MIN_RST;
      hour_r <= `HOUR_RST;
      day_r <= `DAY_RST;
      date_r <= `DATE_RST;
      month_r <= `MONTH_RST;
      year_r <= `YEAR_RST;
    end else if (clkEn) begin
      if (load) begin
        {year_r, month_r, date_r, day_r, hour_r, min_r, sec_r} <= loadVal;
      end else if (tick) begin
        sec_r <= bcdStep(sec_r, 8'h59, 8'h00);
        if (secWrap) begin
          min_r <= bcdStep(min_r, 8'h59, 8'h00);
        end
        if (minWrap) begin
          hour_r <= bcdStep(hour_r, 8'h23, 8'h00);
        end
        if (hourWrap) begin
          day_r <= bcdStep(day_r, 8'h07, 8'h01);
          date_r <= bcdStep(date_r, lastDate(month_r, year_r), 8'h01);
        end
        if (dateWrap) begin
          month_r <= bcdStep(month_r, 8'h12, 8'h01);
        end
        if (monthWrap) begin
          year_r <= bcdStep(year_r, 8'h99, 8'h00);
        end
      end
    end
  end
endmodule

/* File: rtl/battery_backed_sram_rtc_port.v */
// 8k x 8 battery-backed sram whose top eight bytes window a real time clock
// assumes asynchronous host pins, a timekeeping clock pin and supply monitor levels
//
// Overview of operation
// - 13-bit address selects one of 8192 bytes
// - top eight bytes hold clock information
// - clock values bcd, hours in 24-hour form
// - calendar handles all month lengths, leap years
// - byte 1ff8 is clock control; calibration bits stored, not applied
// - clock bytes refreshed from counters every second
// - clock bytes separate from running counters
// - out of tolerance: no writes, hi-z, ignore
// - on battery: keep data and keep counting
// - read mode: strobe high, selects active
// - drive data only when read and output-enabled
// - early enable shows invalid data until access
// - address change: hold, invalid, then new data
// - write mode: strobe low, selects active
// - write spans last start to first end
// - strobe low turns data drivers off
// - writes need no special sequence, unlimited
// - freeze bit six stops per-second copy
// - load bit seven: clearing loads counters
// - power trip: alert and deselect at once, down state after delay
`timescale 1ns/10ps
`include "rtc_sram_map.vh"
module battery_backed_sram_rtc_port #(
  parameter ADDR_W = `ADDR_WIDTH,
  parameter DEPTH = `MEM_WORDS,
  parameter RTC_DIV = `RTC_DIV_DEFAULT,
  parameter PF_DESEL_CYC = `PF_DESEL_CYC,
  parameter RECOVER_CYC = `RECOVER_CYC
) (
  input wire clk_sys,
  input wire rst_n,
  input wire clkEn,
  input wire selectOneN,
  input wire selectTwo,
  input wire outEnN,
  input wire writeStrobeN,
  input wire [ADDR_W-1:0] addrLines,
  input wire [7:0] dataLinesIn,
  input wire powerGood,
  input wire onBattery,
  input wire rtcClkIn,
  output reg [7:0] dataLinesOut,
  output reg dataLinesOeN,
  output reg alertOut,
  output reg alertOeN
);
  localparam SW = ADDR_W + 15;
  localparam [SW-1:0] SYNC_RST = {1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1,
                                  {ADDR_W{1'b0}}, 8'h00};
  localparam [7:0] ACC_CYC = `ACCESS_CYC;
  localparam [15:0] PF_CYC = PF_DESEL_CYC;
  localparam [15:0] REC_CYC = RECOVER_CYC;
  localparam [31:0] DIV_LAST = RTC_DIV - 1;
  // power states
  localparam [1:0] PW_OK = 2'h0;
  localparam [1:0] PW_TRIP = 2'h1;
  localparam [1:0] PW_DOWN = 2'h2;
  localparam [1:0] PW_RECOVER = 2'h3;

  wire [SW-1:0] syncOut;
  wire e1nS;
  wire e2S;
  wire gnS;
  wire wnS;
  wire pgS;
  wire batS;
  wire rtcS;
  wire [ADDR_W-1:0] addrS;
  wire [7:0] dataS;
  wire deselect;
  wire sel;
  wire rdMode;
  wire wrMode;
  wire wrCommit;
  wire secTick;
  wire [55:0] timeVal;
  wire [55:0] loadVal;

  reg [7:0] mem [0:DEPTH-1];
  reg [7:0] clkReg [1:7];
  reg [7:0] ctrl_r;
  reg [7:0] rdByte;
  reg wrMode_r;
  reg [ADDR_W-1:0] wrAddr_r;
  reg [7:0] wrData_r;
  reg rdMode_r;
  reg [ADDR_W-1:0] prevAddr_r;
  reg [7:0] accCnt_r;
  reg [7:0] accCnt_nxt;
  reg [7:0] dataOut_nxt;
  reg rtcPrev_r;
  reg [31:0] divCnt_r;
  reg secTick_r;
  reg copyPend_r;
  reg loadPulse_r;
  reg [1:0] pwState_r;
  reg [15:0] pwCnt_r;
  integer k;

  // clock window: top eight addresses of the array
  function isClock;
    input [ADDR_W-1:0] a;
    begin
      isClock = (a[ADDR_W-1:3] == {(ADDR_W-3){1'b1}});
    end
  endfunction

  pin_sync #(
    .W(SW),
    .RST_VAL(SYNC_RST)
  ) u_sync (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .clkEn(clkEn),
    .pinIn({selectOneN, selectTwo, outEnN, writeStrobeN, powerGood, onBattery, rtcClkIn,
            addrLines, dataLinesIn}),
    .pinOut(syncOut)
  );

  assign {e1nS, e2S, gnS, wnS, pgS, batS, rtcS, addrS, dataS} = syncOut;

  // mode decode
  assign deselect = (pwState_r != PW_OK) || batS;
  assign sel = !e1nS && e2S && !deselect;
  assign rdMode = sel && wnS;
  assign wrMode = sel && !wnS;
  // write ends at the first control to drop; power loss aborts it
  assign wrCommit = wrMode_r && !wrMode && !deselect;

  // read mux over array, control byte and clock bytes
  always @* begin
    rdByte = mem[addrS];
    if (isClock(addrS)) begin
      if (addrS[2:0] == `CTRL_IDX) begin
        rdByte = ctrl_r;
      end else begin
        rdByte = clkReg[addrS[2:0]];
      end
    end
  end

  // plain array: any number of writes, no special sequence
  always @(posedge clk_sys) begin
    if (clkEn && wrCommit && !isClock(wrAddr_r)) begin
      mem[wrAddr_r] <= wrData_r;
    end
  end

  // write capture: address and data sampled while the write is active
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      wrMode_r <= 1'b0;
      wrAddr_r <= {ADDR_W{1'b0}};
      wrData_r <= 8'h00;
    end else if (clkEn) begin
      wrMode_r <= wrMode;
      if (wrMode) begin
        wrAddr_r <= addrS;
        wrData_r <= dataS;
      end
    end
  end

  // control byte and clock window bytes
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      ctrl_r <= `CTRL_RST;
      loadPulse_r <= 1'b0;
      for (k = 1; k < 8; k = k + 1) begin
        clkReg[k] <= 8'h00;
      end
    end else if (clkEn) begin
      loadPulse_r <= 1'b0;
      if (copyPend_r && !ctrl_r[`CTRL_FREEZE_BIT] && !ctrl_r[`CTRL_LOAD_BIT]) begin
        for (k = 1; k < 8; k = k + 1) begin
          clkReg[k] <= timeVal[k*8-8 +: 8];
        end
      end
      if (wrCommit && isClock(wrAddr_r)) begin
        if (wrAddr_r[2:0] == `CTRL_IDX) begin
          ctrl_r <= wrData_r;
          if (ctrl_r[`CTRL_LOAD_BIT] && !wrData_r[`CTRL_LOAD_BIT]) begin
            loadPulse_r <= 1'b1;
          end
        end else begin
          clkReg[wrAddr_r[2:0]] <= wrData_r;
        end
      end
    end
  end

  assign loadVal = {clkReg[7], clkReg[6], clkReg[5], clkReg[4],
                    clkReg[3], clkReg[2], clkReg[1]};

  // second tick from the timekeeping clock, counting even on battery
  assign secTick = rtcS && !rtcPrev_r && (divCnt_r == DIV_LAST);

  always @(posedge clk_sys) begin
    if (!rst_n) begin
      rtcPrev_r <= 1'b0;
      divCnt_r <= 32'h0000_0000;
      secTick_r <= 1'b0;
      copyPend_r <= 1'b0;
    end else if (clkEn) begin
      rtcPrev_r <= rtcS;
      if (rtcS && !rtcPrev_r) begin
        if (divCnt_r == DIV_LAST) begin
          divCnt_r <= 32'h0000_0000;
        end else begin
          divCnt_r <= divCnt_r + 32'h0000_0001;
        end
      end
      secTick_r <= secTick;
      copyPend_r <= secTick_r;
    end
  end

  bcd_time_counter u_time (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .clkEn(clkEn),
    .tick(secTick_r),
    .load(loadPulse_r),
    .loadVal(loadVal),
    .timeVal(timeVal)
  );

  // power monitor: alert and deselect at once, down state after a timed delay, recover after return
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      pwState_r <= PW_OK;
      pwCnt_r <= 16'h0000;
      alertOut <= 1'b0;
      alertOeN <= 1'b1;
    end else if (clkEn) begin
      alertOut <= 1'b0;
      alertOeN <= pgS;
      case (pwState_r)
        PW_OK: begin
          if (!pgS) begin
            alertOeN <= 1'b0;
            pwCnt_r <= PF_CYC;
            pwState_r <= PW_TRIP;
          end
        end
        PW_TRIP: begin
          if (pwCnt_r <= 16'h0001) begin
            pwState_r <= PW_DOWN;
          end else begin
            pwCnt_r <= pwCnt_r - 16'h0001;
          end
        end
        PW_DOWN: begin
          if (pgS) begin
            pwCnt_r <= REC_CYC;
            pwState_r <= PW_RECOVER;
          end
        end
        PW_RECOVER: begin
          if (!pgS) begin
            pwState_r <= PW_DOWN;
          end else if (pwCnt_r <= 16'h0001) begin
            pwState_r <= PW_OK;
          end else begin
            pwCnt_r <= pwCnt_r - 16'h0001;
          end
        end
        default: begin
          pwState_r <= PW_DOWN;
        end
      endcase
    end
  end

  // read access timing: hold on change, invalid until access completes
  always @* begin
    accCnt_nxt = accCnt_r;
    dataOut_nxt = dataLinesOut;
    if (rdMode && (!rdMode_r || addrS != prevAddr_r)) begin
      accCnt_nxt = ACC_CYC;
      if (!rdMode_r) begin
        dataOut_nxt = `DATA_INVALID;
      end
    end else if (accCnt_r != 8'h00) begin
      accCnt_nxt = accCnt_r - 8'h01;
      dataOut_nxt = `DATA_INVALID;
    end else if (rdMode) begin
      dataOut_nxt = rdByte;
    end
  end

  always @(posedge clk_sys) begin
    if (!rst_n) begin
      rdMode_r <= 1'b0;
      prevAddr_r <= {ADDR_W{1'b0}};
      accCnt_r <= 8'h00;
      dataLinesOut <= 8'h00;
      dataLinesOeN <= 1'b1;
    end else if (clkEn) begin
      rdMode_r <= rdMode;
      prevAddr_r <= addrS;
      accCnt_r <= accCnt_nxt;
      dataLinesOut <= dataOut_nxt;
      dataLinesOeN <= !(rdMode && !gnS);
    end
  end
endmodule

/* File: dv/sram_rtc_asserts.sv */
// assertions on the sram and clock window pins
// assumes binding onto the design top; one clock domain
`timescale 1ns/10ps
module sram_rtc_asserts #(
  parameter ADDR_W = 13
) (
  input wire clk_sys,
  input wire rst_n,
  input wire selectOneN,
  input wire selectTwo,
  input wire outEnN,
  input wire writeStrobeN,
  input wire [ADDR_W-1:0] addrLines,
  input wire powerGood,
  input wire onBattery,
  input wire [7:0] dataLinesOut,
  input wire dataLinesOeN,
  input wire alertOut,
  input wire alertOeN
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);
  sequence s_readOn;
    (!selectOneN && selectTwo && !outEnN && writeStrobeN && powerGood && !onBattery) [*8];
  endsequence
  sequence s_addrMove;
    !dataLinesOeN ##1 (!dataLinesOeN && $changed(addrLines));
  endsequence
  property p_readDrive; s_readOn |-> !dataLinesOeN; endproperty
  a_readDrive: assert property (p_readDrive) else $error("read not driven");
  property p_deselHiz; (selectOneN || !selectTwo) [*6] |-> dataLinesOeN; endproperty
  a_deselHiz: assert property (p_deselHiz) else $error("driven deselected");
  property p_oeHiz; outEnN [*6] |-> dataLinesOeN; endproperty
  a_oeHiz: assert property (p_oeHiz) else $error("driven with oe high");
  property p_strobeHiz; (!writeStrobeN) [*6] |-> dataLinesOeN; endproperty
  a_strobeHiz: assert property (p_strobeHiz) else $error("driven in write");
  property p_earlyBad; $fell(dataLinesOeN) |-> dataLinesOut == 8'hff; endproperty
  a_earlyBad: assert property (p_earlyBad) else $error("early data not invalid");
  property p_addrMove; s_addrMove |-> ##[1:8] dataLinesOut == 8'hff; endproperty
  a_addrMove: assert property (p_addrMove) else $error("no invalid after move");
  property p_powerHiz; (!powerGood) [*6] |-> dataLinesOeN; endproperty
  a_powerHiz: assert property (p_powerHiz) else $error("driven on bad supply");
  property p_battHiz; onBattery [*6] |-> dataLinesOeN; endproperty
  a_battHiz: assert property (p_battHiz) else $error("driven on battery");
  property p_alertTrip; $fell(powerGood) |-> ##[1:6] !alertOeN; endproperty
  a_alertTrip: assert property (p_alertTrip) else $error("alert late");
  property p_alertLow; (!powerGood) [*6] |-> !alertOeN && alertOut == 1'b0; endproperty
  a_alertLow: assert property (p_alertLow) else $error("alert not low");
  property p_alertIdle; powerGood [*6] |-> alertOeN; endproperty
  a_alertIdle: assert property (p_alertIdle) else $error("alert stuck");
endmodule

bind battery_backed_sram_rtc_port sram_rtc_asserts #(.ADDR_W(ADDR_W)) u_sram_rtc_asserts (
  .clk_sys(clk_sys), .rst_n(rst_n), .selectOneN(selectOneN), .selectTwo(selectTwo),
  .outEnN(outEnN), .writeStrobeN(writeStrobeN), .addrLines(addrLines),
  .powerGood(powerGood), .onBattery(onBattery), .dataLinesOut(dataLinesOut),
  .dataLinesOeN(dataLinesOeN), .alertOut(alertOut), .alertOeN(alertOeN));

/* File: dv/host_bus.sv */
// host bus master model for the sram pins
// assumes clk_sys; pins change 1 ns after a rising edge
`timescale 1ns/10ps
module host_bus (
  input wire clk_sys,
  input wire [7:0] dataLinesIn,
  output logic selectOneN,
  output logic selectTwo,
  output logic outEnN,
  output logic writeStrobeN,
  output logic [12:0] addrLines,
  output logic [7:0] hostData,
  output logic hostDrive
);
  initial begin
    selectOneN = 1'b1;
    selectTwo = 1'b0;
    outEnN = 1'b1;
    writeStrobeN = 1'b1;
    addrLines = 13'h0000;
    hostData = 8'h00;
    hostDrive = 1'b0;
  end
  task step(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  // write; oe set means outputs are on before the strobe falls
  task wr(input [12:0] a, input [7:0] d, input oe);
    addrLines = a;
    selectOneN = 1'b0;
    selectTwo = 1'b1;
    outEnN = !oe;
    if (oe) step(8);
    writeStrobeN = 1'b0;
    // with outputs on, wait for the block to release the lines before driving them
    if (oe) step(6);
    hostData = d;
    hostDrive = 1'b1;
    step(5);
    writeStrobeN = 1'b1;
    step(1);
    selectTwo = 1'b0;
    outEnN = 1'b1;
    hostDrive = 1'b0;
    step(6);
  endtask
  // read at a, then move to b with outputs held on
  task rd(input [12:0] a, input [12:0] b, output [7:0] d);
    addrLines = a;
    selectOneN = 1'b0;
    selectTwo = 1'b1;
    outEnN = 1'b0;
    step(8);
    addrLines = b;
    step(8);
    d = dataLinesIn;
    selectOneN = 1'b1;
    outEnN = 1'b1;
    step(6);
  endtask
endmodule

/* File: dv/testbench.sv */
// self-checking bench for the sram with clock window
// assumes host_bus drives the pins; short second and power counts
`timescale 1ns/10ps
module testbench;
  logic clk_sys, rst_n, powerGood, onBattery, rtcClkIn, clkEn;
  wire selectOneN, selectTwo, outEnN, writeStrobeN, hostDrive;
  wire dataLinesOeN, alertOut, alertOeN;
  wire [12:0] addrLines;
  wire [7:0] hostData, dataLinesOut, busLevel;
  logic [7:0] lastLevel = 8'h00;
  logic [7:0] d0;
  int failCount, compares;
  // a released line shows the inverse of its last level
  assign busLevel = !dataLinesOeN ? dataLinesOut : hostDrive ? hostData : ~lastLevel;
  always @(posedge clk_sys) lastLevel <= busLevel;
  host_bus u_host_bus (.clk_sys(clk_sys), .dataLinesIn(busLevel), .selectOneN(selectOneN),
    .selectTwo(selectTwo), .outEnN(outEnN), .writeStrobeN(writeStrobeN),
    .addrLines(addrLines), .hostData(hostData), .hostDrive(hostDrive));
  battery_backed_sram_rtc_port #(.RTC_DIV(4), .PF_DESEL_CYC(3), .RECOVER_CYC(2))
    u_battery_backed_sram_rtc_port (.clk_sys(clk_sys), .rst_n(rst_n), .clkEn(clkEn),
    .selectOneN(selectOneN), .selectTwo(selectTwo), .outEnN(outEnN),
    .writeStrobeN(writeStrobeN), .addrLines(addrLines), .dataLinesIn(busLevel),
    .powerGood(powerGood), .onBattery(onBattery), .rtcClkIn(rtcClkIn),
    .dataLinesOut(dataLinesOut), .dataLinesOeN(dataLinesOeN), .alertOut(alertOut),
    .alertOeN(alertOeN));
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  initial begin
    rtcClkIn = 1'b0;
    forever #400 rtcClkIn = ~rtcClkIn;
  end
  task check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      failCount++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task rdChk(input [12:0] a, input [7:0] exp);
    u_host_bus.rd(a, a, d0);
    check($sformatf("byte %h", a), d0, exp);
  endtask
  task t_reset;
    check("oeN", {7'h0, dataLinesOeN}, 8'h01);
    check("alertOeN", {7'h0, alertOeN}, 8'h01);
    rdChk(13'h1ff8, 8'h00);
  endtask
  task t_mem;
    logic [12:0] a [4];
    a = '{13'h0000, 13'h0001, 13'h1000, 13'h1ff7};
    foreach (a[i]) u_host_bus.wr(a[i], {4'h3, 4'(i)}, 1'b0);
    u_host_bus.wr(13'h0000, 8'hc3, 1'b0);
    foreach (a[i]) rdChk(a[i], i == 0 ? 8'hc3 : {4'h3, 4'(i)});
    u_host_bus.wr(13'h1ff8, 8'h15, 1'b0);
    rdChk(13'h1ff8, 8'h15);
    u_host_bus.wr(13'h1ff8, 8'h00, 1'b0);
  endtask
  task t_oeWrite;
    u_host_bus.wr(13'h0005, 8'h5a, 1'b1);
    rdChk(13'h0005, 8'h5a);
    u_host_bus.rd(13'h0001, 13'h1000, d0);
    check("moved read", d0, 8'h32);
  endtask
  task t_clock;
    logic [7:0] v [7];
    logic [7:0] e [6];
    v = '{8'h59, 8'h59, 8'h23, 8'h03, 8'h28, 8'h02, 8'h24};
    e = '{8'h00, 8'h00, 8'h04, 8'h29, 8'h02, 8'h24};
    u_host_bus.wr(13'h1ff8, 8'h80, 1'b0);
    foreach (v[i]) u_host_bus.wr(13'(13'h1ff9 + i), v[i], 1'b0);
    u_host_bus.wr(13'h1ff8, 8'h00, 1'b0);
    u_host_bus.step(40);
    foreach (e[i]) rdChk(13'(13'h1ffa + i), e[i]);
    u_host_bus.rd(13'h1ff9, 13'h1ff9, d0);
    check("sec tens", {4'h0, d0[7:4]}, 8'h00);
  endtask
  task t_freeze;
    logic [7:0] s0, s1;
    u_host_bus.wr(13'h1ff8, 8'h40, 1'b0);
    u_host_bus.rd(13'h1ff9, 13'h1ff9, s0);
    u_host_bus.step(120);
    rdChk(13'h1ff9, s0);
    u_host_bus.wr(13'h1ff8, 8'h00, 1'b0);
    u_host_bus.step(40);
    u_host_bus.rd(13'h1ff9, 13'h1ff9, s1);
    d0 = (s1[7:4] * 8'd10 + s1[3:0]) - (s0[7:4] * 8'd10 + s0[3:0]);
    check("sec run", {7'h0, d0 > 8'd4}, 8'h01);
  endtask
  task t_hold;
    logic [7:0] s0, s1;
    u_host_bus.rd(13'h1ff9, 13'h1ff9, s0);
    clkEn = 1'b0;
    u_host_bus.step(160);
    clkEn = 1'b1;
    u_host_bus.rd(13'h1ff9, 13'h1ff9, s1);
    d0 = (s1[7:4] * 8'd10 + s1[3:0]) - (s0[7:4] * 8'd10 + s0[3:0]);
    check("held secs", {7'h0, d0 <= 8'd1}, 8'h01);
  endtask
  task t_power;
    powerGood = 1'b0;
    onBattery = 1'b1;
    u_host_bus.step(8);
    check("alert on", {7'h0, alertOeN}, 8'h00);
    u_host_bus.wr(13'h0001, 8'h99, 1'b0);
    powerGood = 1'b1;
    onBattery = 1'b0;
    u_host_bus.step(12);
    check("alert off", {7'h0, alertOeN}, 8'h01);
    rdChk(13'h0001, 8'h31);
  endtask
  task report_and_stop;
    $display("compares %0d mismatches %0d", compares, failCount);
    if (failCount == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial begin
    failCount = 0;
    compares = 0;
    powerGood = 1'b1;
    onBattery = 1'b0;
    clkEn = 1'b1;
    rst_n = 1'b0;
    repeat (2) @(posedge clk_sys);
    #1 rst_n = 1'b1;
    t_reset;
    t_mem;
    t_oeWrite;
    t_clock;
    t_freeze;
    t_hold;
    t_power;
    report_and_stop;
  end
  initial begin
    #1000000;
    failCount++;
    report_and_stop;
  end
endmodule
